/* src/sbd_drive.sv */
// Sensorless three-phase drive control: PWM, sampling, commutation, faults, knob
// Behaviour
// - PWM counter is two chained 8-bit halves forming one 16-bit count.
// - Period modulus 1250 bus ticks at 25 MHz gives 50 us.
// - Chained 16-bit compare sets delay from period start to sample trigger.
// - Converter: single conversion, external trigger, 10-bit, 6.25 MHz, left-justified.
// - Sampled input is the floating phase of the current sector.
// - Each sample: read phase and bus, check overvoltage, test zero crossing.
// - One sample trigger per PWM period, every 50 us.
// - Timer 1 schedules commutation; timer 2 gives a 1 ms loop tick.
// - Dead-time command byte matches 100x xxx1 on the serial link.
// - Dead-time calibration value resets to 600.
// - Six direct gate outputs plus a separate serial setup port.
// - Serial link configures predriver first and reads back its status.
// - External fault input raises a fault event.
// - Any fault forces all six gate outputs off.
// - Fault state holds until the fault clears, then goes to stop.
// - Each knob press toggles between run and stop while cfg_done is set and no fault is present.
// - Clockwise raises, anticlockwise lowers speed by 200 rpm.
// - Speed starts at 800 rpm, never below 800 nor above 1600.
// - Bus current taken signed about 2.5 V, fed to loop and overcurrent check.
// - High-side gates come from the one shared PWM and the sector; low-side gates from the sector level alone.
`timescale 1ns/1ps
module sbd_drive import sbd_pkg::*; #(
   parameter int TICK_CYCLES = TICK_1MS_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Knob pins
   input wire logic knob_press,
   input wire logic knob_cw,
   input wire logic knob_ccw,
   // Protection
   input wire logic fault_latch_out,
   input wire logic fault_clear,
   input wire logic [15:0] ov_limit,
   input wire logic [15:0] oc_limit,
   // Loop settings
   input wire logic [15:0] duty_in,
   input wire logic [15:0] trig_delay_in,
   input wire logic [15:0] comm_delay_in,
   // Predriver setup
   input wire logic [15:0] dt_cal_in,
   input wire logic dt_cal_load,
   input wire logic status_req,
   // Converter
   output logic adc_clk_en,
   output logic adc_start,
   output logic [2:0] adc_float_sel,
   input wire logic adc_done,
   input wire sbd_adc_s adc_res,
   // Gate drive
   output sbd_gate_s gate,
   // Serial pins
   output logic spi_sclk,
   output logic spi_mosi,
   output logic spi_cs_n,
   input wire logic spi_miso,
   // Status
   output logic [10:0] speed_setpoint,
   output logic motor_running,
   output logic fault_irq,
   output logic loop_tick,
   output logic [15:0] bus_current_signed,
   output logic [7:0] predrv_status,
   output logic cfg_done
);
   localparam int TICK_W = $clog2(TICK_CYCLES);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   sbd_state_e state_q;
   sbd_sector_s smap;
   logic [1:0] bdiv_q;
   logic [3:0] adiv_q;
   logic bus_tick;
   logic [7:0] cnt_lo_q;
   logic [7:0] cnt_hi_q;
   logic [15:0] pwm_cnt;
   logic period_end;
   logic [15:0] duty_q;
   logic [15:0] trig_q;
   logic pwm_level;
   logic [2:0] sector_q;
   logic armed_q;
   logic [15:0] comm_q;
   logic prev_valid_q;
   logic prev_above_q;
   logic above;
   logic zc;
   logic commutate;
   logic signed [15:0] cur_s;
   logic [15:0] cur_abs;
   logic sw_set;
   logic sw_fault_q;
   logic [1:0] flt_sync_q;
   logic flt_d_q;
   logic any_fault;
   logic [2:0] k1_q;
   logic [2:0] k2_q;
   logic [2:0] k3_q;
   logic [2:0] krise;
   logic [TICK_W-1:0] tick_q;
   logic [15:0] dt_cal_q;
   logic dt_pend_q;
   logic st_pend_q;
   logic st_frame_q;
   logic spi_ready;
   logic spi_done;
   logic spi_start;
   logic [7:0] spi_rx;
   logic [23:0] spi_tx;

   // Enable dividers: 25 MHz bus tick and 6.25 MHz converter clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bdiv_q <= 2'h0;
         adiv_q <= 4'h0;
         adc_clk_en <= 1'b0;
      end else begin
         bdiv_q <= bus_tick ? 2'h0 : bdiv_q + 2'h1;
         adiv_q <= (adiv_q == ADC_DIV_LAST) ? 4'h0 : adiv_q + 4'h1;
         adc_clk_en <= (adiv_q == ADC_DIV_LAST);
      end
   end
   assign bus_tick = (bdiv_q == BUS_DIV_LAST);

   // Chained 8-bit halves; high half steps on low-half carry
   assign pwm_cnt = {cnt_hi_q, cnt_lo_q};
   assign period_end = bus_tick && (pwm_cnt == PWM_LAST);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_lo_q <= 8'h00;
         cnt_hi_q <= 8'h00;
      end else if (period_end) begin
         cnt_lo_q <= 8'h00;
         cnt_hi_q <= 8'h00;
      end else if (bus_tick) begin
         cnt_lo_q <= cnt_lo_q + 8'h01;
         if (cnt_lo_q == 8'hFF) begin
            cnt_hi_q <= cnt_hi_q + 8'h01;
         end
      end
   end

   // Shadowed duty and trigger delay; loaded at the wrap so a period never mixes values
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         duty_q <= DUTY_RESET;
         trig_q <= TRIG_RESET;
      end else if (period_end) begin
         duty_q <= duty_in;
         trig_q <= trig_delay_in;
      end
   end
   assign pwm_level = (pwm_cnt < duty_q);

   // One trigger per period at the delay compare match
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         adc_start <= 1'b0;
      end else begin
         adc_start <= bus_tick && (pwm_cnt == trig_q);
      end
   end

   // Sample evaluation: floating-phase zero crossing and bus checks
   assign above = adc_res.phase > {1'b0, adc_res.bus_v[15:1]};
   assign zc = adc_done && (state_q == ST_RUN) && prev_valid_q && (above != prev_above_q);
   assign cur_s = signed'(adc_res.bus_i - ADC_OFFSET);
   assign cur_abs = cur_s[15] ? 16'(-cur_s) : 16'(cur_s);
   assign sw_set = adc_done && ((adc_res.bus_v > ov_limit) || (cur_abs > oc_limit));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_valid_q <= 1'b0;
         prev_above_q <= 1'b0;
         bus_current_signed <= 16'h0000;
      end else begin
         if (commutate || state_q != ST_RUN) begin
            prev_valid_q <= 1'b0;
         end else if (adc_done) begin
            prev_valid_q <= 1'b1;
            prev_above_q <= above;
         end
         if (adc_done) begin
            bus_current_signed <= cur_s;
         end
      end
   end

   // Timer 1: zero crossing arms the delay, expiry commutates
   assign commutate = armed_q && bus_tick && (comm_q == 16'h0000);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         armed_q <= 1'b0;
         comm_q <= 16'h0000;
         sector_q <= 3'h0;
      end else if (state_q != ST_RUN) begin
         armed_q <= 1'b0;
      end else if (commutate) begin
         armed_q <= 1'b0;
         sector_q <= (sector_q == SECTOR_LAST) ? 3'h0 : sector_q + 3'h1;
      end else if (zc && !armed_q) begin
         armed_q <= 1'b1;
         comm_q <= comm_delay_in;
      end else if (armed_q && bus_tick) begin
         comm_q <= comm_q - 16'h0001;
      end
   end

   // Timer 2: 1 ms loop tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_q <= '0;
         loop_tick <= 1'b0;
      end else begin
         tick_q <= (tick_q == TICK_LAST) ? '0 : tick_q + TICK_W'(1);
         loop_tick <= (tick_q == TICK_LAST);
      end
   end

   // Fault pin and knob pins cross in on two flops, third flop for edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flt_sync_q <= 2'b00;
         flt_d_q <= 1'b0;
         k1_q <= 3'b000;
         k2_q <= 3'b000;
         k3_q <= 3'b000;
      end else begin
         flt_sync_q <= {flt_sync_q[0], fault_latch_out};
         flt_d_q <= flt_sync_q[1];
         k1_q <= {knob_press, knob_cw, knob_ccw};
         k2_q <= k1_q;
         k3_q <= k2_q;
      end
   end
   assign krise = k2_q & ~k3_q;

   // Sticky software fault; a new detection beats a same-cycle clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sw_fault_q <= 1'b0;
         fault_irq <= 1'b0;
      end else begin
         if (sw_set) begin
            sw_fault_q <= 1'b1;
         end else if (fault_clear) begin
            sw_fault_q <= 1'b0;
         end
         fault_irq <= flt_sync_q[1] && !flt_d_q;
      end
   end
   assign any_fault = flt_sync_q[1] | sw_fault_q;

   // Drive state: run and stop by knob, fault overrides
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_STOP;
      end else begin
         case (state_q)
            ST_STOP: begin
               if (any_fault) state_q <= ST_FAULT;
               else if (krise[2] && cfg_done) state_q <= ST_RUN;
            end
            ST_RUN: begin
               if (any_fault) state_q <= ST_FAULT;
               else if (krise[2]) state_q <= ST_STOP;
            end
            ST_FAULT: begin
               if (!any_fault) state_q <= ST_STOP;
            end
            default: state_q <= ST_STOP;
         endcase
      end
   end
   assign motor_running = (state_q == ST_RUN);

   // Speed setpoint, clamped to its range
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         speed_setpoint <= SPEED_MIN;
      end else if (krise[1] && !krise[0] && speed_setpoint < SPEED_MAX) begin
         speed_setpoint <= speed_setpoint + SPEED_STEP;
      end else if (krise[0] && !krise[1] && speed_setpoint > SPEED_MIN) begin
         speed_setpoint <= speed_setpoint - SPEED_STEP;
      end
   end

   // Gate and sample select from the sector; gates all off outside run or on fault, sample select always follows the sector
   assign smap = sector_map(sector_q);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gate <= '0;
         adc_float_sel <= 3'b000;
      end else begin
         adc_float_sel <= smap.flt;
         if (any_fault || state_q != ST_RUN) begin
            gate <= '0;
         end else begin
            gate.hs <= smap.hi & {3{pwm_level}};
            gate.ls <= smap.lo;
         end
      end
   end

   // Predriver setup: dead time sent after reset and on reload, status on request
   assign spi_start = spi_ready && (dt_pend_q || st_pend_q);
   assign spi_tx = dt_pend_q ? {DT_CMD, dt_cal_q} : {STATUS_CMD, 16'h0000};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dt_cal_q <= DT_CAL_RESET;
         dt_pend_q <= 1'b1;
         st_pend_q <= 1'b0;
         st_frame_q <= 1'b0;
         cfg_done <= 1'b0;
         predrv_status <= 8'h00;
      end else begin
         if (dt_cal_load) begin
            dt_cal_q <= dt_cal_in;
            dt_pend_q <= 1'b1;
         end else if (spi_start && dt_pend_q) begin
            dt_pend_q <= 1'b0;
         end
         if (status_req) begin
            st_pend_q <= 1'b1;
         end else if (spi_start && !dt_pend_q) begin
            st_pend_q <= 1'b0;
         end
         if (spi_start) begin
            st_frame_q <= !dt_pend_q;
         end
         if (spi_done && !st_frame_q) begin
            cfg_done <= 1'b1;
         end
         if (spi_done && st_frame_q) begin
            predrv_status <= spi_rx;
         end
      end
   end

   sbd_spi_xfer u_spi (
      .clk(clk),
      .rst(rst),
      .start(spi_start),
      .tx_data(spi_tx),
      .ready(spi_ready),
      .done(spi_done),
      .rx_byte(spi_rx),
      .spi_sclk(spi_sclk),
      .spi_mosi(spi_mosi),
      .spi_cs_n(spi_cs_n),
      .spi_miso(spi_miso)
   );

   // Checks
   sequence s_zc_arm;
      zc && !armed_q && !commutate;
   endsequence
   sequence s_fault_wait;
      state_q == ST_FAULT && any_fault;
   endsequence
   a_gates_off_fault: assert property (@(posedge clk) disable iff (rst)
      any_fault |=> gate == '0) else $error("gates active during fault");
   a_fault_hold: assert property (@(posedge clk) disable iff (rst)
      s_fault_wait |=> state_q == ST_FAULT) else $error("left fault early");
   a_fault_exit: assert property (@(posedge clk) disable iff (rst)
      state_q == ST_FAULT && !any_fault |=> state_q == ST_STOP) else $error("no stop");
   a_zc_arm: assert property (@(posedge clk) disable iff (rst)
      s_zc_arm |=> armed_q && comm_q == $past(comm_delay_in)) else $error("timer not armed");
   a_sector_step: assert property (@(posedge clk) disable iff (rst)
      commutate && state_q == ST_RUN |=> sector_q == ($past(sector_q) == SECTOR_LAST ? 3'h0 :
      $past(sector_q) + 3'h1)) else $error("bad sector advance");
   a_speed_range: assert property (@(posedge clk) disable iff (rst)
      speed_setpoint >= SPEED_MIN && speed_setpoint <= SPEED_MAX) else $error("speed range");
   a_speed_up: assert property (@(posedge clk) disable iff (rst)
      krise == 3'b010 && speed_setpoint < SPEED_MAX |=> speed_setpoint ==
      $past(speed_setpoint) + SPEED_STEP) else $error("speed step");
   a_trig_single: assert property (@(posedge clk) disable iff (rst)
      adc_start |=> !adc_start [*8]) else $error("double trigger");
   a_trig_match: assert property (@(posedge clk) disable iff (rst)
      adc_start |-> $past(pwm_cnt) == trig_q) else $error("trigger off delay");
   a_duty_shadow: assert property (@(posedge clk) disable iff (rst)
      !$past(period_end) |-> $stable(duty_q)) else $error("duty changed mid period");
   a_dt_cmd_form: assert property (@(posedge clk) disable iff (rst)
      spi_start && dt_pend_q |-> (spi_tx[23:16] & DT_CMD_MASK) == DT_CMD) else $error("cmd");
   a_float_idle: assert property (@(posedge clk) disable iff (rst)
      ((gate.hs | gate.ls) & adc_float_sel) == 3'b000) else $error("sampled leg driven");
   a_knob_toggle: assert property (@(posedge clk) disable iff (rst)
      state_q == ST_RUN && krise[2] && !any_fault |=> state_q == ST_STOP) else $error("toggle");
endmodule // sbd_drive

/* shared/sbd_pkg.sv */
// Shared constants, types and sector decoding for the sensorless drive control
package sbd_pkg;
   // Clock rates and enable dividers
   localparam int CLK_HZ = 100_000_000;
   localparam int BUS_HZ = 25_000_000;
   localparam int ADC_HZ = 6_250_000;
   localparam logic [1:0] BUS_DIV_LAST = 2'(CLK_HZ / BUS_HZ - 1);
   localparam logic [3:0] ADC_DIV_LAST = 4'(CLK_HZ / ADC_HZ - 1);
   // PWM period: 1250 bus ticks, 50 us
   localparam logic [15:0] PWM_MODULUS = 16'h04E2;
   localparam logic [15:0] PWM_LAST = PWM_MODULUS - 16'h0001;
   localparam logic [15:0] DUTY_RESET = 16'h0000;
   localparam logic [15:0] TRIG_RESET = 16'h0000;
   // Loop timebase, 1 ms
   localparam int TICK_MS = 1;
   localparam int TICK_1MS_CYC = CLK_HZ / 1000 * TICK_MS;
   // Predriver serial commands and dead-time calibration (600)
   localparam logic [7:0] DT_CMD = 8'h81;
   localparam logic [7:0] DT_CMD_MASK = 8'hE1;
   localparam logic [7:0] STATUS_CMD = 8'h20;
   localparam logic [15:0] DT_CAL_RESET = 16'h0258;
   localparam logic [3:0] SPI_HALF_LAST = 4'h7;
   localparam logic [4:0] SPI_LAST_BIT = 5'h17;
   // Speed setpoint in rpm: 800 min, 1600 max, 200 step
   localparam logic [10:0] SPEED_MIN = 11'h320;
   localparam logic [10:0] SPEED_MAX = 11'h640;
   localparam logic [10:0] SPEED_STEP = 11'h0C8;
   // Bus current zero point: 2.5 V of a 5 V left-justified scale
   localparam logic [15:0] ADC_OFFSET = 16'h8000;
   localparam logic [2:0] SECTOR_LAST = 3'h5;

   typedef enum logic [2:0] {
      ST_STOP = 3'b001,
      ST_RUN = 3'b010,
      ST_FAULT = 3'b100
   } sbd_state_e;

   // One conversion set, each value 10-bit left-justified
   typedef struct packed {
      logic [15:0] phase;
      logic [15:0] bus_v;
      logic [15:0] bus_i;
   } sbd_adc_s;

   typedef struct packed {
      logic [2:0] hs;
      logic [2:0] ls;
   } sbd_gate_s;

   // One-hot phases per sector: high-side, low-side, floating
   typedef struct packed {
      logic [2:0] hi;
      logic [2:0] lo;
      logic [2:0] flt;
   } sbd_sector_s;

   function automatic sbd_sector_s sector_map(input logic [2:0] s);
      sbd_sector_s m;
      case (s)
         3'h0: m = '{hi: 3'b001, lo: 3'b010, flt: 3'b100};
         3'h1: m = '{hi: 3'b001, lo: 3'b100, flt: 3'b010};
         3'h2: m = '{hi: 3'b010, lo: 3'b100, flt: 3'b001};
         3'h3: m = '{hi: 3'b010, lo: 3'b001, flt: 3'b100};
         3'h4: m = '{hi: 3'b100, lo: 3'b001, flt: 3'b010};
         3'h5: m = '{hi: 3'b100, lo: 3'b010, flt: 3'b001};
         default: m = '{hi: 3'b000, lo: 3'b000, flt: 3'b000};
      endcase
      return m;
   endfunction
endpackage

/* src/sbd_spi_xfer.sv */
// Serial master for predriver setup and status, 24-bit frames, mode 0
`timescale 1ns/1ps
module sbd_spi_xfer import sbd_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Frame request
   input wire logic start,
   input wire logic [23:0] tx_data,
   output logic ready,
   output logic done,
   output logic [7:0] rx_byte,
   // Serial pins
   output logic spi_sclk,
   output logic spi_mosi,
   output logic spi_cs_n,
   input wire logic spi_miso
);
   logic run_q;
   logic sclk_q;
   logic done_q;
   logic [3:0] div_q;
   logic [4:0] bit_q;
   logic [23:0] sh_q;
   logic [7:0] rx_q;
   logic m1_q;
   logic m2_q;

   // Pin input crosses in on two flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         m1_q <= 1'b0;
         m2_q <= 1'b0;
      end else begin
         m1_q <= spi_miso;
         m2_q <= m1_q;
      end
   end

   // Shift engine; data changes on falling edge, sampled on rising edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_q <= 1'b0;
         sclk_q <= 1'b0;
         done_q <= 1'b0;
         div_q <= 4'h0;
         bit_q <= 5'h00;
         sh_q <= 24'h000000;
         rx_q <= 8'h00;
      end else begin
         done_q <= 1'b0;
         if (!run_q) begin
            if (start) begin
               run_q <= 1'b1;
               sh_q <= tx_data;
               bit_q <= 5'h00;
               div_q <= 4'h0;
            end
         end else if (div_q != SPI_HALF_LAST) begin
            div_q <= div_q + 4'h1;
         end else begin
            div_q <= 4'h0;
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
               rx_q <= {rx_q[6:0], m2_q};
            end else begin
               sh_q <= {sh_q[22:0], 1'b0};
               if (bit_q == SPI_LAST_BIT) begin
                  run_q <= 1'b0;
                  done_q <= 1'b1;
               end else begin
                  bit_q <= bit_q + 5'h01;
               end
            end
         end
      end
   end

   assign ready = ~run_q;
   assign done = done_q;
   assign rx_byte = rx_q;
   assign spi_sclk = sclk_q;
   assign spi_mosi = sh_q[23];
   assign spi_cs_n = ~run_q;
endmodule // sbd_spi_xfer

/* dv/sbd_far_model.sv */
// Far-side model: converter answering triggers and predriver serial slave
`timescale 1ns/1ps
module sbd_far_model import sbd_pkg::*; #(
   parameter int LAT = 20,
   parameter logic [7:0] STAT = 8'hA5
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Converter side
   input wire logic adc_start,
   input wire sbd_adc_s adc_val,
   output logic adc_done,
   output sbd_adc_s adc_res,
   // Serial side
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   input wire logic spi_cs_n,
   output logic spi_miso,
   output logic [23:0] frame
);
   logic [23:0] sh_q;
   logic [2:0] n_q;
   logic idle_q;
   int cnt;
   // Fixed conversion time; result lines garbage outside the done cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
      end else if (adc_start) begin
         cnt <= LAT;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
   assign adc_done = (cnt == 1);
   assign adc_res = adc_done ? adc_val : ~adc_val;
   // Mode 0 slave: sample on rise, shift out on fall
   always_ff @(posedge spi_sclk) sh_q <= {sh_q[22:0], spi_mosi};
   always_ff @(posedge spi_cs_n) frame <= sh_q;
   always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         n_q <= 3'h0;
      end else begin
         n_q <= n_q + 3'h1;
      end
   end
   // Deselected line keeps moving so no stale bit is trusted
   always_ff @(posedge clk) idle_q <= rst ? 1'b0 : ~idle_q;
   assign spi_miso = spi_cs_n ? idle_q : STAT[3'h7 - n_q];
endmodule // sbd_far_model

/* dv/sbd_drive_bench.sv */
// Self-checking bench for the drive control block
`timescale 1ns/1ps
module sbd_drive_bench import sbd_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic knob_press, knob_cw, knob_ccw, fault_latch_out, fault_clear, status_req, dt_cal_load;
   logic [15:0] ov_limit, oc_limit, duty_in, trig_delay_in, bus_current_signed, dt_cal_in;
   logic adc_clk_en, adc_start, adc_done, spi_sclk, spi_mosi, spi_cs_n, spi_miso;
   logic motor_running, fault_irq, loop_tick, cfg_done;
   logic [2:0] adc_float_sel;
   logic [10:0] speed_setpoint, spd;
   logic [7:0] predrv_status;
   logic [23:0] frame;
   sbd_adc_s adc_res, adc_val;
   sbd_gate_s gate;
   int err_count = 0;
   int tests_run = 0;
   int n;
   always #5 clk = ~clk;
   sbd_drive #(.TICK_CYCLES(100)) u_dut (.clk(clk), .rst(rst), .knob_press(knob_press),
      .knob_cw(knob_cw), .knob_ccw(knob_ccw), .fault_latch_out(fault_latch_out),
      .fault_clear(fault_clear), .ov_limit(ov_limit), .oc_limit(oc_limit), .duty_in(duty_in),
      .trig_delay_in(trig_delay_in), .comm_delay_in(16'h0010), .dt_cal_in(dt_cal_in),
      .dt_cal_load(dt_cal_load), .status_req(status_req), .adc_clk_en(adc_clk_en),
      .adc_start(adc_start), .adc_float_sel(adc_float_sel), .adc_done(adc_done),
      .adc_res(adc_res), .gate(gate), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
      .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .speed_setpoint(speed_setpoint),
      .motor_running(motor_running), .fault_irq(fault_irq), .loop_tick(loop_tick),
      .bus_current_signed(bus_current_signed), .predrv_status(predrv_status),
      .cfg_done(cfg_done));
   sbd_far_model #(.LAT(20), .STAT(8'h5A)) u_far (.clk(clk), .rst(rst),
      .adc_start(adc_start), .adc_val(adc_val), .adc_done(adc_done), .adc_res(adc_res),
      .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
      .frame(frame));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Cycles until the next pulse of one output; a hang ends the run
   task automatic gap(input int w, output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1;
         c++;
      end while (!(w == 0 ? adc_start : w == 1 ? loop_tick : w == 2 ? adc_clk_en : fault_irq)
         && c < 30000);
      if (c >= 30000) begin
         err_count++;
         report_and_stop();
      end
   endtask
   // One knob pin held long enough to pass the synchronisers
   task automatic knob(input int k);
      {knob_ccw, knob_cw, knob_press} = 3'(1 << k);
      repeat (4) @(negedge clk);
      {knob_ccw, knob_cw, knob_press} = 3'h0;
      repeat (4) @(negedge clk);
   endtask
   // Expected setpoint after one step, clamped to 800..1600
   function automatic logic [10:0] next_speed(input logic [10:0] s, input bit up);
      if (up) return (s >= 11'h578) ? 11'h640 : s + 11'h0C8;
      return (s <= 11'h3E8) ? 11'h320 : s - 11'h0C8;
   endfunction
   initial begin
      {knob_press, knob_cw, knob_ccw, fault_latch_out, fault_clear, status_req, dt_cal_load} = 7'h00;
      dt_cal_in = 16'h0258;
      ov_limit = 16'hFFFF;
      oc_limit = 16'hFFFF;
      duty_in = 16'h0200;
      trig_delay_in = 16'h0064;
      adc_val = '{phase: 16'h0000, bus_v: 16'h8000, bus_i: 16'h8000};
      void'($urandom(27));
      repeat (5) @(negedge clk);
      chk("reset_out", {gate, speed_setpoint, motor_running, spi_cs_n}, 19'h00C81);
      repeat (5) @(negedge clk);
      rst = 1'b0;
      // Dead-time frame goes out first after reset
      for (n = 0; n < 2000 && cfg_done !== 1'b1; n++) @(negedge clk);
      repeat (4) @(negedge clk);
      chk("cfg_done", cfg_done, 1);
      chk("dt_frame", frame, 24'h810258);
      chk("dt_pattern", frame[23:16] & 8'hE1, 8'h81);
      if (n == 2000) report_and_stop();
      status_req = 1'b1;
      @(negedge clk);
      status_req = 1'b0;
      for (n = 0; n < 2000 && predrv_status !== 8'h5A; n++) @(negedge clk);
      repeat (4) @(negedge clk);
      chk("status", predrv_status, 8'h5A);
      chk("st_frame", frame, 24'h200000);
      // Reloaded calibration must go out again as a dead-time frame
      dt_cal_in = 16'($urandom);
      dt_cal_load = 1'b1;
      @(negedge clk);
      dt_cal_load = 1'b0;
      for (n = 0; n < 2000 && frame !== {8'h81, dt_cal_in}; n++) @(negedge clk);
      chk("dt_reload", frame, {8'h81, dt_cal_in});
      // Clamp corners first, then random steps
      spd = 11'h320;
      for (int i = 0; i < 16; i++) begin
         n = (i < 5) ? 1 : (i < 10) ? 2 : $urandom_range(2, 1);
         knob(n);
         spd = next_speed(spd, n == 1);
         chk("speed", speed_setpoint, spd);
      end
      gap(0, n);
      gap(0, n);
      chk("period", n, 5000);
      @(negedge clk);
      trig_delay_in = 16'($urandom_range(1200, 10));
      duty_in = 16'($urandom_range(1249, 0));
      adc_val.bus_i = 16'($urandom_range(65535, 0));
      gap(0, n);
      chk("trig_move", n, 5000 + 4 * (trig_delay_in - 100));
      repeat (30) @(negedge clk);
      chk("bus_i", bus_current_signed, 16'(adc_val.bus_i - 16'h8000));
      chk("float_sel", $countones(adc_float_sel), 1);
      gap(2, n);
      gap(2, n);
      chk("adc_clk", n, 16);
      gap(1, n);
      gap(1, n);
      chk("tick", n, 100);
      @(negedge clk);
      adc_val.bus_i = 16'h8000;
      knob(0);
      chk("run", motor_running, 1);
      chk("gate_split", gate.hs & gate.ls, 0);
      // Sign flip of the floating phase; one sample sets the reference first
      chk("float_s0", adc_float_sel, 3'b100);
      gap(0, n);
      repeat (30) @(negedge clk);
      adc_val.phase = 16'hFFFF;
      gap(0, n);
      repeat (200) @(negedge clk);
      chk("float_s1", adc_float_sel, 3'b010);
      chk("gate_lo", gate.ls, 3'b100);
      adc_val.phase = 16'h0000;
      oc_limit = 16'h1000;
      adc_val.bus_i = 16'hA000;
      gap(0, n);
      repeat (30) @(negedge clk);
      chk("oc_stop", {motor_running, gate}, 0);
      adc_val.bus_i = 16'h8000;
      fault_clear = 1'b1;
      repeat (5) @(negedge clk);
      fault_clear = 1'b0;
      chk("oc_clear", motor_running, 0);
      knob(0);
      chk("rerun", motor_running, 1);
      fault_latch_out = 1'b1;
      gap(3, n);
      chk("irq_delay", n <= 4, 1);
      repeat (2) @(negedge clk);
      chk("pin_stop", {motor_running, gate}, 0);
      knob(0);
      chk("held", {motor_running, gate}, 0);
      fault_latch_out = 1'b0;
      repeat (20) @(negedge clk);
      knob(0);
      chk("restart", motor_running, 1);
      knob(0);
      chk("stop", motor_running, 0);
      report_and_stop();
   end
endmodule // sbd_drive_bench
